/* File: logic/tssm_cfg.svh */
`ifndef TSSM_CFG_SVH
`define TSSM_CFG_SVH

// Register word indexes; byte address is index times four
`define TSSM_IDX_W          10
`define TSSM_DRV_CTL_IDX    10'h014
`define TSSM_TX_SEL_IDX     10'h016
`define TSSM_TEST_SEL_IDX   10'h031

// Reset values
`define TSSM_TX_SEL_RST     8'h10
`define TSSM_DRV_CTL_RST    8'h00
`define TSSM_TEST_SEL_RST   8'h00

// transmit_source_select fields
`define TSSM_RSVD_HI        7
`define TSSM_RSVD_LO        6
`define TSSM_DRV_SRC_HI     5
`define TSSM_DRV_SRC_LO     4
`define TSSM_AUX_SRC_HI     3
`define TSSM_AUX_SRC_LO     0

// driver_control fields
`define TSSM_INV2_ON_BIT    7
`define TSSM_INV1_ON_BIT    6
`define TSSM_INV2_OFF_BIT   5
`define TSSM_INV1_OFF_BIT   4
`define TSSM_EN2_BIT        1
`define TSSM_EN1_BIT        0

// test_select_one field
`define TSSM_BIT_CHOICE_HI  2
`define TSSM_BIT_CHOICE_LO  0

`endif

/* File: logic/tssm_pkg.sv */
package tssm_pkg;

  typedef enum logic [1:0] {
    TSSM_DRV_TRI   = 2'b00,
    TSSM_DRV_CODER = 2'b01,
    TSSM_DRV_AUXIN = 2'b10,
    TSSM_DRV_HIGH  = 2'b11
  } tssm_drv_src_t;

  typedef enum logic [3:0] {
    TSSM_AUX_TRI      = 4'h0,
    TSSM_AUX_LOW      = 4'h1,
    TSSM_AUX_HIGH     = 4'h2,
    TSSM_AUX_TESTBUS  = 4'h3,
    TSSM_AUX_CODER    = 4'h4,
    TSSM_AUX_TXSER    = 4'h5,
    TSSM_AUX_RXREGEN  = 4'h6,
    TSSM_AUX_RXSER    = 4'h7,
    TSSM_AUX_HS_RX    = 4'h8,
    TSSM_AUX_HS_TX    = 4'h9,
    TSSM_AUX_HS_COMP  = 4'ha,
    TSSM_AUX_HS_RSVD  = 4'hb,
    TSSM_AUX_A_RXC    = 4'hc,
    TSSM_AUX_A_TXC    = 4'hd,
    TSSM_AUX_A_RXRAW  = 4'he,
    TSSM_AUX_A_ENVRAW = 4'hf
  } tssm_aux_src_t;

  typedef struct packed {
    tssm_drv_src_t drv_src;
    tssm_aux_src_t aux_src;
    logic [7:0]    drv_ctl;
    logic [2:0]    bit_choice;
    logic [1:0]    auxin_sync;
    logic          aux_lvl;
    logic          aux_oe_n;
    logic [31:0]   rdata;
  } tssm_top_state_t;

  typedef struct packed {
    logic pin;
    logic oe_n;
  } tssm_stage_state_t;

endpackage

/* File: logic/tssm_drv_stage.sv */
`timescale 1ns/1ps
`default_nettype none

module tssm_drv_stage
  import tssm_pkg::*;
(
  input  wire logic sys_clk_i,    // Core clock
  input  wire logic reset_i,      // Sync reset
  input  wire logic tri_i,        // Release the pin
  input  wire logic src_i,        // Selected source level
  input  wire logic en_i,         // Driver enabled
  input  wire logic inv_on_i,     // Invert while enabled
  input  wire logic inv_off_i,    // Invert while disabled
  output logic      pin_o,        // Pin level
  output logic      pin_oe_n_o    // Low while driving
);
  import tssm_pkg::*;

  tssm_stage_state_t st_ff;
  tssm_stage_state_t nxt_st;

  always_comb begin
    nxt_st      = st_ff;
    nxt_st.oe_n = tri_i;
    // Disabled driver carries no envelope, only the off inversion
    nxt_st.pin  = (en_i ? src_i : 1'b0) ^ (en_i ? inv_on_i : inv_off_i);
  end

  // Registered so mux switching never glitches the pin
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      st_ff <= '{pin: 1'b0, oe_n: 1'b1};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign pin_o      = st_ff.pin;
  assign pin_oe_n_o = st_ff.oe_n;

endmodule // tssm_drv_stage

`default_nettype wire

/* File: logic/tssm_top.sv */
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "tssm_cfg.svh"

module tssm_top
  import tssm_pkg::*;
(
  input  wire logic        sys_clk_i,          // 100 MHz core clock
  input  wire logic        reset_i,            // Sync reset, active high
  input  wire logic        psel_i,             // APB select
  input  wire logic        penable_i,          // APB access phase
  input  wire logic        pwrite_i,           // APB write
  input  wire logic [11:0] paddr_i,            // APB byte address
  input  wire logic [31:0] pwdata_i,           // APB write data
  input  wire logic [3:0]  pstrb_i,            // APB byte strobes
  output logic             pready_o,           // APB ready
  output logic [31:0]      prdata_o,           // APB read data
  output logic             pslverr_o,          // APB error
  input  wire logic        soft_power_down_i,  // Core in soft power-down
  input  wire logic        coder_envelope_i,   // Internal coder envelope
  input  wire logic        tx_serial_i,        // Serial stream being sent
  input  wire logic        rx_regen_i,         // Regenerated card modulation
  input  wire logic        rx_serial_i,        // Received serial stream
  input  wire logic [7:0]  test_bus_i,         // Internal test bus
  input  wire logic        hs_sam_rx_i,        // Fast scheme module rx
  input  wire logic        hs_sam_tx_i,        // Fast scheme module tx
  input  wire logic        demod_comp_i,       // Demodulator comparator
  input  wire logic        a_sam_rx_carrier_i, // Type A rx with carrier
  input  wire logic        a_sam_tx_carrier_i, // Type A tx with carrier
  input  wire logic        a_sam_rx_raw_i,     // Type A rx unfiltered
  input  wire logic        a_sam_env_raw_i,    // Type A envelope unfiltered
  input  wire logic        aux_signal_input_i, // Aux input pin
  output logic             aux_signal_output_o,      // Aux output pin
  output logic             aux_signal_output_oe_n_o, // Low while driving
  output logic             antenna_driver_one_o,     // Driver one level
  output logic             antenna_driver_one_oe_n_o,// Low while driving
  output logic             antenna_driver_two_o,     // Driver two level
  output logic             antenna_driver_two_oe_n_o // Low while driving
);
  import tssm_pkg::*;

  tssm_top_state_t st_ff;
  tssm_top_state_t nxt_st;

  localparam logic [7:0] tx_sel_rst = `TSSM_TX_SEL_RST;

  logic [`TSSM_IDX_W-1:0] word_idx;
  logic                   hit_tx_sel;
  logic                   hit_drv_ctl;
  logic                   hit_test_sel;
  logic                   hit_any;
  logic                   setup_ph;
  logic                   wr_en;
  logic [7:0]             tx_sel_rd;
  logic [7:0]             rd_word;
  logic                   drv_tri;
  logic                   drv_src_lvl;
  logic [1:0]             drv_en;
  logic [1:0]             drv_inv_on;
  logic [1:0]             drv_inv_off;
  logic [1:0]             drv_pin;
  logic [1:0]             drv_oe_n;

  assign word_idx     = paddr_i[11:2];
  assign hit_tx_sel   = word_idx == `TSSM_TX_SEL_IDX;
  assign hit_drv_ctl  = word_idx == `TSSM_DRV_CTL_IDX;
  assign hit_test_sel = word_idx == `TSSM_TEST_SEL_IDX;
  assign hit_any      = hit_tx_sel | hit_drv_ctl | hit_test_sel;
  assign setup_ph     = psel_i & ~penable_i;

  // Zero wait state; error on unmapped word
  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i & penable_i & ~hit_any;
  assign wr_en     = psel_i & penable_i & pwrite_i & hit_any & pstrb_i[0];

  // Reserved top bits read zero
  assign tx_sel_rd = {2'b00, st_ff.drv_src, st_ff.aux_src};

  always_comb begin
    rd_word = 8'h00;
    if (hit_tx_sel) begin
      rd_word = tx_sel_rd;
    end else if (hit_drv_ctl) begin
      rd_word = st_ff.drv_ctl;
    end else if (hit_test_sel) begin
      rd_word = {5'h00, st_ff.bit_choice};
    end
  end

  always_comb begin
    nxt_st            = st_ff;
    nxt_st.auxin_sync = {st_ff.auxin_sync[0], aux_signal_input_i};
    if (setup_ph) begin
      nxt_st.rdata = {24'h000000, rd_word};
    end
    if (wr_en && hit_tx_sel) begin
      // Bits 7:6 discarded
      nxt_st.drv_src = tssm_drv_src_t'(pwdata_i[`TSSM_DRV_SRC_HI:`TSSM_DRV_SRC_LO]);
      nxt_st.aux_src = tssm_aux_src_t'(pwdata_i[`TSSM_AUX_SRC_HI:`TSSM_AUX_SRC_LO]);
    end
    if (wr_en && hit_drv_ctl) begin
      nxt_st.drv_ctl = pwdata_i[7:0];
    end
    if (wr_en && hit_test_sel) begin
      nxt_st.bit_choice = pwdata_i[`TSSM_BIT_CHOICE_HI:`TSSM_BIT_CHOICE_LO];
    end
    // Aux output mux, registered for glitch-free switching
    nxt_st.aux_oe_n = 1'b0;
    nxt_st.aux_lvl  = 1'b0;
    unique case (st_ff.aux_src)
      TSSM_AUX_TRI:      nxt_st.aux_oe_n = 1'b1;
      TSSM_AUX_LOW:      nxt_st.aux_lvl  = 1'b0;
      TSSM_AUX_HIGH:     nxt_st.aux_lvl  = 1'b1;
      TSSM_AUX_TESTBUS:  nxt_st.aux_lvl  = test_bus_i[st_ff.bit_choice];
      TSSM_AUX_CODER:    nxt_st.aux_lvl  = coder_envelope_i;
      TSSM_AUX_TXSER:    nxt_st.aux_lvl  = tx_serial_i;
      TSSM_AUX_RXREGEN:  nxt_st.aux_lvl  = rx_regen_i;
      TSSM_AUX_RXSER:    nxt_st.aux_lvl  = rx_serial_i;
      TSSM_AUX_HS_RX:    nxt_st.aux_lvl  = hs_sam_rx_i;
      TSSM_AUX_HS_TX:    nxt_st.aux_lvl  = hs_sam_tx_i;
      TSSM_AUX_HS_COMP:  nxt_st.aux_lvl  = demod_comp_i;
      TSSM_AUX_HS_RSVD:  nxt_st.aux_lvl  = 1'b0;
      TSSM_AUX_A_RXC:    nxt_st.aux_lvl  = a_sam_rx_carrier_i;
      TSSM_AUX_A_TXC:    nxt_st.aux_lvl  = a_sam_tx_carrier_i;
      TSSM_AUX_A_RXRAW:  nxt_st.aux_lvl  = a_sam_rx_raw_i;
      TSSM_AUX_A_ENVRAW: nxt_st.aux_lvl  = a_sam_env_raw_i;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      st_ff.drv_src    <= tssm_drv_src_t'(tx_sel_rst[`TSSM_DRV_SRC_HI:`TSSM_DRV_SRC_LO]);
      st_ff.aux_src    <= tssm_aux_src_t'(tx_sel_rst[`TSSM_AUX_SRC_HI:`TSSM_AUX_SRC_LO]);
      st_ff.drv_ctl    <= `TSSM_DRV_CTL_RST;
      st_ff.bit_choice <= 3'(`TSSM_TEST_SEL_RST);
      st_ff.auxin_sync <= 2'b00;
      st_ff.aux_lvl    <= 1'b0;
      st_ff.aux_oe_n   <= 1'b1;
      st_ff.rdata      <= 32'h00000000;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign prdata_o                 = st_ff.rdata;
  assign aux_signal_output_o      = st_ff.aux_lvl;
  assign aux_signal_output_oe_n_o = st_ff.aux_oe_n;

  // Common driver source; power-down disables but only code 00 tristates
  assign drv_tri = st_ff.drv_src == TSSM_DRV_TRI;

  always_comb begin
    unique case (st_ff.drv_src)
      TSSM_DRV_TRI:   drv_src_lvl = 1'b0;
      TSSM_DRV_CODER: drv_src_lvl = coder_envelope_i;
      TSSM_DRV_AUXIN: drv_src_lvl = st_ff.auxin_sync[1];
      TSSM_DRV_HIGH:  drv_src_lvl = 1'b1;
    endcase
  end

  assign drv_en      = {st_ff.drv_ctl[`TSSM_EN2_BIT], st_ff.drv_ctl[`TSSM_EN1_BIT]}
                       & {2{~soft_power_down_i}};
  assign drv_inv_on  = {st_ff.drv_ctl[`TSSM_INV2_ON_BIT], st_ff.drv_ctl[`TSSM_INV1_ON_BIT]};
  assign drv_inv_off = {st_ff.drv_ctl[`TSSM_INV2_OFF_BIT], st_ff.drv_ctl[`TSSM_INV1_OFF_BIT]};

  for (genvar g = 0; g < 2; g++) begin : g_drv
    tssm_drv_stage u_stage (
      .sys_clk_i  (sys_clk_i),
      .reset_i    (reset_i),
      .tri_i      (drv_tri),
      .src_i      (drv_src_lvl),
      .en_i       (drv_en[g]),
      .inv_on_i   (drv_inv_on[g]),
      .inv_off_i  (drv_inv_off[g]),
      .pin_o      (drv_pin[g]),
      .pin_oe_n_o (drv_oe_n[g])
    );
  end

  assign antenna_driver_one_o      = drv_pin[0];
  assign antenna_driver_one_oe_n_o = drv_oe_n[0];
  assign antenna_driver_two_o      = drv_pin[1];
  assign antenna_driver_two_oe_n_o = drv_oe_n[1];

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);

  sequence s_tx_sel_wr;
    psel_i && penable_i && pwrite_i && hit_tx_sel && pstrb_i[0];
  endsequence

  sequence s_tx_sel_rd;
    psel_i && !penable_i && !pwrite_i && hit_tx_sel ##1 psel_i && penable_i;
  endsequence

  chk_rsvd_read: assert property (
    s_tx_sel_rd |-> prdata_o[7:6] == 2'b00 && prdata_o[5:4] == st_ff.drv_src)
    else $error("reserved bits or driver field read wrong");

  chk_drv_tristate: assert property (
    drv_tri |=> antenna_driver_one_oe_n_o && antenna_driver_two_oe_n_o)
    else $error("drivers not tristated for code 00");

  chk_pd_keep: assert property (
    soft_power_down_i && !drv_tri |=> !antenna_driver_one_oe_n_o
      && antenna_driver_one_o == $past(drv_inv_off[0]))
    else $error("power-down changed driver state wrongly");

  chk_drv_coder: assert property (
    st_ff.drv_src == TSSM_DRV_CODER && drv_en[0] |=>
      antenna_driver_one_o == ($past(coder_envelope_i) ^ $past(drv_inv_on[0])))
    else $error("driver one not following coder envelope");

  chk_drv_auxin: assert property (
    st_ff.drv_src == TSSM_DRV_AUXIN && drv_en[1] |=>
      antenna_driver_two_o == ($past(aux_signal_input_i, 3) ^ $past(drv_inv_on[1])))
    else $error("driver two not following aux input");

  chk_drv_high: assert property (
    st_ff.drv_src == TSSM_DRV_HIGH && drv_en[1] |=>
      antenna_driver_two_o == !$past(drv_inv_on[1]) && !antenna_driver_two_oe_n_o)
    else $error("high level not applied");

  chk_drv_invert: assert property (
    !drv_tri && !drv_en[0] |=> antenna_driver_one_o == $past(drv_inv_off[0]))
    else $error("disabled driver inversion wrong");

  chk_aux_fixed: assert property (
    st_ff.aux_src == TSSM_AUX_HIGH |=> aux_signal_output_o && !aux_signal_output_oe_n_o)
    else $error("aux output not high");

  chk_aux_tri: assert property (
    st_ff.aux_src == TSSM_AUX_TRI |=> aux_signal_output_oe_n_o)
    else $error("aux output not tristated");

  chk_aux_testbus: assert property (
    st_ff.aux_src == TSSM_AUX_TESTBUS |=>
      aux_signal_output_o == $past(test_bus_i[st_ff.bit_choice]))
    else $error("test-bus bit not routed");

  chk_aux_rxregen: assert property (
    st_ff.aux_src == TSSM_AUX_RXREGEN |=> aux_signal_output_o == $past(rx_regen_i))
    else $error("receiver signal not routed");

  chk_aux_hs_tx: assert property (
    st_ff.aux_src == TSSM_AUX_HS_TX |=> aux_signal_output_o == $past(hs_sam_tx_i))
    else $error("fast scheme tx not routed");

  chk_aux_env_raw: assert property (
    st_ff.aux_src == TSSM_AUX_A_ENVRAW |=> aux_signal_output_o == $past(a_sam_env_raw_i))
    else $error("unfiltered envelope not routed");

  chk_aux_low: assert property (
    st_ff.aux_src == TSSM_AUX_LOW |=> !aux_signal_output_o && !aux_signal_output_oe_n_o)
    else $error("aux output not low");

  chk_aux_drives: assert property (
    st_ff.aux_src != TSSM_AUX_TRI |=> !aux_signal_output_oe_n_o)
    else $error("aux output not driven");

  chk_aux_coder: assert property (
    st_ff.aux_src == TSSM_AUX_CODER |=> aux_signal_output_o == $past(coder_envelope_i))
    else $error("coder envelope not routed");

  chk_aux_txser: assert property (
    st_ff.aux_src == TSSM_AUX_TXSER |=> aux_signal_output_o == $past(tx_serial_i))
    else $error("transmit stream not routed");

  chk_aux_rxser: assert property (
    st_ff.aux_src == TSSM_AUX_RXSER |=> aux_signal_output_o == $past(rx_serial_i))
    else $error("receive stream not routed");

  chk_aux_hs_rx: assert property (
    st_ff.aux_src == TSSM_AUX_HS_RX |=> aux_signal_output_o == $past(hs_sam_rx_i))
    else $error("fast scheme rx not routed");

  chk_aux_hs_comp: assert property (
    st_ff.aux_src == TSSM_AUX_HS_COMP |=> aux_signal_output_o == $past(demod_comp_i))
    else $error("comparator output not routed");

  chk_aux_hs_rsvd: assert property (
    st_ff.aux_src == TSSM_AUX_HS_RSVD |=> !aux_signal_output_o)
    else $error("reserved code not low");

  chk_aux_a_rxc: assert property (
    st_ff.aux_src == TSSM_AUX_A_RXC |=> aux_signal_output_o == $past(a_sam_rx_carrier_i))
    else $error("type A rx carrier not routed");

  chk_aux_a_txc: assert property (
    st_ff.aux_src == TSSM_AUX_A_TXC |=> aux_signal_output_o == $past(a_sam_tx_carrier_i))
    else $error("type A tx carrier not routed");

  chk_aux_a_rxraw: assert property (
    st_ff.aux_src == TSSM_AUX_A_RXRAW |=> aux_signal_output_o == $past(a_sam_rx_raw_i))
    else $error("type A unfiltered rx not routed");

  chk_drv_two_coder: assert property (
    st_ff.drv_src == TSSM_DRV_CODER && drv_en[1] |=>
      antenna_driver_two_o == ($past(coder_envelope_i) ^ $past(drv_inv_on[1])))
    else $error("driver two not following coder envelope");

  chk_drv_one_auxin: assert property (
    st_ff.drv_src == TSSM_DRV_AUXIN && drv_en[0] |=>
      antenna_driver_one_o == ($past(aux_signal_input_i, 3) ^ $past(drv_inv_on[0])))
    else $error("driver one not following aux input");

  chk_drv_one_high: assert property (
    st_ff.drv_src == TSSM_DRV_HIGH && drv_en[0] |=>
      antenna_driver_one_o == !$past(drv_inv_on[0]) && !antenna_driver_one_oe_n_o)
    else $error("high level not applied to driver one");

  chk_drv_two_off: assert property (
    !drv_tri && !drv_en[1] |=> antenna_driver_two_o == $past(drv_inv_off[1]))
    else $error("disabled driver two inversion wrong");

  chk_pd_keep_two: assert property (
    soft_power_down_i && !drv_tri |=> !antenna_driver_two_oe_n_o
      && antenna_driver_two_o == $past(drv_inv_off[1]))
    else $error("power-down changed driver two wrongly");

  chk_rdata_upper: assert property (
    s_tx_sel_rd |-> prdata_o[31:8] == 24'h000000)
    else $error("upper read data not zero");

  chk_reset_value: assert property (
    $past(reset_i) |-> tx_sel_rd == `TSSM_TX_SEL_RST && aux_signal_output_oe_n_o)
    else $error("reset value wrong");

  chk_write_effect: assert property (
    s_tx_sel_wr |=>
      st_ff.aux_src == $past(pwdata_i[3:0])
      ##1 aux_signal_output_oe_n_o == ($past(st_ff.aux_src) == TSSM_AUX_TRI))
    else $error("write did not take effect on time");

endmodule // tssm_top

`default_nettype wire

/* File: testbench/tssm_aux_partner.sv */
`timescale 1ns/1ps
`default_nettype none

module tssm_aux_partner (
  input  wire logic sys_clk_i,  // Core clock
  input  wire logic env_i,      // Envelope to send
  output logic      aux_sig_o   // Drives the aux input pin
);
  initial aux_sig_o = 1'b0;
  // External circuit launches its envelope just after the edge
  always @(posedge sys_clk_i) begin
    aux_sig_o <= env_i;
  end
endmodule // tssm_aux_partner

`default_nettype wire

/* File: testbench/tssm_top_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "tssm_cfg.svh"

module tssm_top_tb_top;
  import tssm_pkg::*;
  localparam logic [11:0] A_TX  = {`TSSM_TX_SEL_IDX, 2'b00};
  localparam logic [11:0] A_CTL = {`TSSM_DRV_CTL_IDX, 2'b00};
  localparam logic [11:0] A_TS  = {`TSSM_TEST_SEL_IDX, 2'b00};
  logic        sys_clk, reset, psel, penable, pwrite, pready, pslverr, pd, env, aux_in;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [10:0] src_v;
  logic [7:0]  test_bus;
  logic        aux_out, aux_oe_n, d1, d1_oe_n, d2, d2_oe_n, er;
  int          fail_count = 0;
  int          samples_checked = 0;

  initial sys_clk = 1'b0;
  always #5 sys_clk = ~sys_clk;

  tssm_aux_partner partner (.sys_clk_i(sys_clk), .env_i(env), .aux_sig_o(aux_in));

  tssm_top dut (
    .sys_clk_i(sys_clk), .reset_i(reset), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'hf),
    .pready_o(pready), .prdata_o(prdata), .pslverr_o(pslverr),
    .soft_power_down_i(pd), .coder_envelope_i(src_v[0]), .tx_serial_i(src_v[1]),
    .rx_regen_i(src_v[2]), .rx_serial_i(src_v[3]), .test_bus_i(test_bus),
    .hs_sam_rx_i(src_v[4]), .hs_sam_tx_i(src_v[5]), .demod_comp_i(src_v[6]),
    .a_sam_rx_carrier_i(src_v[7]), .a_sam_tx_carrier_i(src_v[8]),
    .a_sam_rx_raw_i(src_v[9]), .a_sam_env_raw_i(src_v[10]),
    .aux_signal_input_i(aux_in), .aux_signal_output_o(aux_out),
    .aux_signal_output_oe_n_o(aux_oe_n), .antenna_driver_one_o(d1),
    .antenna_driver_one_oe_n_o(d1_oe_n), .antenna_driver_two_o(d2),
    .antenna_driver_two_oe_n_o(d2_oe_n)
  );

  task automatic finish_test();
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic cmp_bit(input logic got, input logic exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t read data got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // One APB transfer; holds the request until pready is seen high, for at most 20 cycles
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      fail_count++;
      finish_test();
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    cmp_word(rd, exp);
  endtask

  function automatic int idx_of(input int k);
    return (k < 4) ? 0 : (k < 12) ? k - 4 : k - 5;
  endfunction

  // Bit choice 5 is set, so test bus bit 5 carries the level
  function automatic logic exp_aux(input int k, input logic v);
    case (k)
      1, 11:   return 1'b0;
      2:       return 1'b1;
      default: return v;
    endcase
  endfunction

  task automatic drv_case(input logic [1:0] code, input logic [7:0] ctl, input logic c,
                          input logic e, input logic p, input logic oe, input logic l1,
                          input logic l2);
    wr(A_CTL, {24'h0, ctl});
    wr(A_TX, {26'h0, code, 4'h0});
    @(posedge sys_clk);
    src_v[0] <= c;
    env      <= e;
    pd       <= p;
    wait_cyc(6);
    cmp_bit(d1_oe_n, oe, "driver one enable");
    cmp_bit(d2_oe_n, oe, "driver two enable");
    if (!oe) begin
      cmp_bit(d1, l1, "driver one level");
      cmp_bit(d2, l2, "driver two level");
    end
  endtask

  initial begin
    repeat (50000) @(posedge sys_clk);
    fail_count++;
    finish_test();
  end

  initial begin
    reset = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h0;
    pwdata = 32'h0; pd = 1'b0; env = 1'b0; src_v = 11'h0; test_bus = 8'h0;
    wait_cyc(4);
    reset <= 1'b0;
    rd_chk(A_TX, 32'h10);
    cmp_bit(d1_oe_n, 1'b0, "driver one after reset");
    cmp_bit(d1, 1'b0, "driver one level after reset");
    cmp_bit(aux_oe_n, 1'b1, "aux after reset");
    wr(A_TX, 32'hff);
    rd_chk(A_TX, 32'h3f);
    cmp_bit(er, 1'b0, "mapped read error");
    apb(1'b0, 12'h100, 32'h0);
    cmp_bit(er, 1'b1, "unmapped error");
    cmp_word(rd, 32'h0);
    wr(A_TS, 32'h5);
    rd_chk(A_TS, 32'h5);
    for (int k = 0; k < 16; k++) begin
      wr(A_TX, 32'h10 | 32'(k));
      for (int v = 0; v < 2; v++) begin
        @(posedge sys_clk);
        src_v    <= v[0] ? (11'h1 << idx_of(k)) : ~(11'h1 << idx_of(k));
        test_bus <= v[0] ? 8'h20 : 8'hdf;
        wait_cyc(3);
        cmp_bit(aux_oe_n, k == 0, "aux enable");
        if (k != 0) cmp_bit(aux_out, exp_aux(k, v[0]), "aux level");
      end
    end
    drv_case(2'b01, 8'h03, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
    drv_case(2'b01, 8'h03, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    drv_case(2'b10, 8'h03, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
    drv_case(2'b10, 8'h03, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    drv_case(2'b11, 8'h03, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
    drv_case(2'b11, 8'h43, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
    drv_case(2'b11, 8'h10, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
    drv_case(2'b00, 8'h03, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    drv_case(2'b01, 8'h23, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
    drv_case(2'b00, 8'h03, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
    finish_test();
  end
endmodule // tssm_top_tb_top

`default_nettype wire
